// ===== logic/spc_baud_gen.sv
// Serial clock generator: toggles every half period while running, idles at a set level.
// Assumes half period of at least one system clock.
`timescale 1ns/100ps
`default_nettype none

module spc_baud_gen #(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Control
  input wire logic run_i,
  input wire logic idle_lvl_i,
  input wire logic [CNT_W-1:0] half_i,
  // Clock out
  output logic sclk_o,
  output logic tick_o
);

  logic [CNT_W-1:0] cnt_r;

  // ----------------------------------------
  // Half period counter
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (!run_i || (cnt_r + CNT_W'(1) >= half_i)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CNT_W'(1);
    end
  end

  // ----------------------------------------
  // Clock level and period tick
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_o <= 1'b0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      sclk_o <= idle_lvl_i;
      tick_o <= 1'b0;
    end else if (cnt_r + CNT_W'(1) >= half_i) begin
      sclk_o <= ~sclk_o;
      tick_o <= (sclk_o != idle_lvl_i);
    end else begin
      tick_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== logic/spc_pkg.sv
// Types and mode decoding of the serial port control block.
// Assumes nothing beyond a SystemVerilog compiler.
package spc_pkg;

  // ----------------------------------------
  // Mode selector codes
  // ----------------------------------------
  typedef enum logic [3:0] {
    SPC_SPI_M_FOSC4 = 4'h0,
    SPC_SPI_M_FOSC16 = 4'h1,
    SPC_SPI_M_ALT2 = 4'h2,
    SPC_SPI_M_ALT3 = 4'h3,
    SPC_SPI_S_SEL = 4'h4,
    SPC_SPI_S_NOSEL = 4'h5,
    SPC_RSVD6 = 4'h6,
    SPC_I2C_S_10 = 4'h7,
    SPC_I2C_M_DIV = 4'h8,
    SPC_RSVD9 = 4'h9,
    SPC_SPI_M_DIV = 4'hA,
    SPC_I2C_M_FW = 4'hB,
    SPC_RSVDC = 4'hC,
    SPC_RSVDD = 4'hD,
    SPC_I2C_S_7_SS = 4'hE,
    SPC_I2C_S_10_SS = 4'hF
  } spc_mode_e;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic spc_is_spi(input logic [3:0] m);
    spc_is_spi = (m <= 4'h5) || (m == 4'hA);
  endfunction

  function automatic logic spc_is_i2c(input logic [3:0] m);
    spc_is_i2c = (m == 4'h7) || (m == 4'h8) || (m == 4'hB) || (m >= 4'hE);
  endfunction

  function automatic logic spc_is_master(input logic [3:0] m);
    spc_is_master = (m <= 4'h3) || (m == 4'h8) || (m == 4'hA) || (m == 4'hB);
  endfunction

endpackage

// ===== logic/spc_regs.svh
// Offsets, field positions, reset values and clock counts of the serial port control block.
// Assumes an 8-bit word address on the register port.
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPC_OFS_CON1      8'h00
`define SPC_OFS_BAUD      8'h04
`define SPC_OFS_BUF       8'h08
`define SPC_OFS_IRQ_STAT  8'h0C
`define SPC_OFS_IRQ_MASK  8'h10
`define SPC_OFS_STATUS    8'h14

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define SPC_BIT_COLL      7
`define SPC_BIT_OVF       6
`define SPC_BIT_EN        5
`define SPC_BIT_POL       4
`define SPC_CON1_WR_MASK  8'h3F
`define SPC_CON1_RST      8'h00
`define SPC_BAUD_RST      8'h00

// ----------------------------------------
// Interrupt and status fields
// ----------------------------------------
`define SPC_IRQ_N         3
`define SPC_IRQ_COLL      0
`define SPC_IRQ_OVF       1
`define SPC_IRQ_RX        2
`define SPC_IRQ_RST       3'h0
`define SPC_ST_CFG_ERR    0
`define SPC_ST_BUF_FULL   1
`define SPC_ST_BUSY       2

// ----------------------------------------
// Clock half periods in system clocks
// ----------------------------------------
`define SPC_HALF_FOSC4    10'h002
`define SPC_HALF_FOSC16   10'h008
`define SPC_HALF_FOSC64   10'h020
`define SPC_I2C_DIV_MIN   8'h03

`endif

// ===== logic/spc_serial_port_control.sv
// Serial port control register 1 with flags, enable, clock control and mode decode.
// Assumes a shift engine outside that reports busy and received bytes.
//
// Function
// - Buffer write while shifting sets write collision
// - SPI byte into full buffer: overflow, discard
// - SPI overflow only in slave mode
// - I2C receive into full buffer sets overflow
// - SPI enable claims clock, data, select pins; code claims select pin only in code 0100
// - I2C enable claims SDA and SCL pins
// - SPI clock idles at polarity bit level
// - I2C slave holds SCL low while bit clear
// - Codes 1111, 1110, 0111 select I2C slave
// - Code 1011 is firmware I2C master
// - Code 1010 SPI master, divider clock
// - Code 1000 I2C master, divider; 0-2 invalid
// - Code 0101 SPI slave, select pin free
// - Code 0001 SPI master at clock/16
//
// Chosen here: the register addresses and the address-and-strobe port.
`include "spc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module spc_serial_port_control #(
  parameter int CNT_W = 10
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Shift engine
  input wire logic shift_busy_i,
  input wire logic rx_done_i,
  input wire logic [7:0] rx_data_i,
  input wire logic i2c_tx_dir_i,
  input wire logic xfer_run_i,
  output logic [7:0] tx_data_o,
  output logic tx_load_o,
  // Mode outputs
  output logic [3:0] mode_o,
  output logic i2c_addr10_o,
  output logic i2c_start_stop_irq_o,
  output logic i2c_fw_master_o,
  // Pin ownership and clock
  output logic spi_pins_own_o,
  output logic ss_pin_own_o,
  output logic i2c_pins_own_o,
  output logic sclk_o,
  output logic bit_tick_o,
  output logic scl_hold_low_o,
  // Interrupt
  output logic irq_o
);

  logic [1:0] rst_sync_r;
  logic rst_n;
  logic [7:0] con1_r;
  logic [7:0] baud_r;
  logic [7:0] buf_r;
  logic buf_full_r;
  logic [`SPC_IRQ_N-1:0] irq_mask_r;
  logic [`SPC_IRQ_N-1:0] irq_stat;
  logic [`SPC_IRQ_N-1:0] irq_set;
  logic [`SPC_IRQ_N-1:0] irq_clr;
  logic [3:0] mode;
  logic en;
  logic pol;
  logic is_spi;
  logic is_i2c;
  logic is_master;
  logic wr_con1;
  logic wr_buf;
  logic rd_buf;
  logic coll_set;
  logic ovf_set;
  logic rx_take;
  logic cfg_err;
  logic gen_run;
  logic [CNT_W-1:0] half_nxt;
  logic [CNT_W-1:0] half_r;
  logic [7:0] rdata_nxt;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign mode = con1_r[3:0];
  assign en = con1_r[`SPC_BIT_EN];
  assign pol = con1_r[`SPC_BIT_POL];
  assign is_spi = spc_pkg::spc_is_spi(mode);
  assign is_i2c = spc_pkg::spc_is_i2c(mode);
  assign is_master = spc_pkg::spc_is_master(mode);
  assign wr_con1 = reg_wr_i && (reg_addr_i == `SPC_OFS_CON1);
  assign wr_buf = reg_wr_i && (reg_addr_i == `SPC_OFS_BUF);
  assign rd_buf = reg_rd_i && (reg_addr_i == `SPC_OFS_BUF);

  // Collision only when a word is still shifting out
  assign coll_set = en && wr_buf && shift_busy_i;

  // Overflow in SPI slave or I2C receive only
  assign ovf_set = en && rx_done_i && buf_full_r &&
                   ((is_spi && !is_master) ||
                    (is_i2c && !i2c_tx_dir_i));
  // Byte into full buffer is dropped
  assign rx_take = en && rx_done_i && !buf_full_r;

  // I2C master with divider 0..2 or SPI master with divider 0
  assign cfg_err = ((mode == spc_pkg::SPC_I2C_M_DIV) && (baud_r < `SPC_I2C_DIV_MIN)) ||
                   ((mode == spc_pkg::SPC_SPI_M_DIV) && (baud_r == 8'h00));

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      con1_r <= `SPC_CON1_RST;
    end else begin
      if (wr_con1) begin
        con1_r[5:0] <= reg_wdata_i[5:0];
      end
      if (coll_set) begin
        con1_r[`SPC_BIT_COLL] <= 1'b1;
      end else if (wr_con1 && !reg_wdata_i[`SPC_BIT_COLL]) begin
        con1_r[`SPC_BIT_COLL] <= 1'b0;
      end
      if (ovf_set) begin
        con1_r[`SPC_BIT_OVF] <= 1'b1;
      end else if (wr_con1 && !reg_wdata_i[`SPC_BIT_OVF]) begin
        con1_r[`SPC_BIT_OVF] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      baud_r <= `SPC_BAUD_RST;
    end else if (reg_wr_i && (reg_addr_i == `SPC_OFS_BAUD)) begin
      baud_r <= reg_wdata_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask_r <= `SPC_IRQ_RST;
    end else if (reg_wr_i && (reg_addr_i == `SPC_OFS_IRQ_MASK)) begin
      irq_mask_r <= reg_wdata_i[`SPC_IRQ_N-1:0];
    end
  end

  // ----------------------------------------
  // Transfer buffer
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      buf_r <= 8'h00;
      buf_full_r <= 1'b0;
    end else begin
      if (rx_take) begin
        buf_r <= rx_data_i;
      end
      if (rx_take) begin
        buf_full_r <= 1'b1;
      end else if (rd_buf) begin
        buf_full_r <= 1'b0;
      end
    end
  end

  // Accepted write starts a transfer, colliding one is dropped
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tx_data_o <= 8'h00;
      tx_load_o <= 1'b0;
    end else begin
      tx_load_o <= en && wr_buf && !shift_busy_i;
      if (en && wr_buf && !shift_busy_i) begin
        tx_data_o <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  assign irq_set = {rx_take, ovf_set, coll_set};

  genvar gi;
  generate
    for (gi = 0; gi < `SPC_IRQ_N; gi++) begin : g_irq
      assign irq_clr[gi] = reg_wr_i && (reg_addr_i == `SPC_OFS_IRQ_STAT) && reg_wdata_i[gi];
      spc_sticky u_flag (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .set_i(irq_set[gi]),
        .clr_i(irq_clr[gi]),
        .q_o(irq_stat[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat & irq_mask_r);
    end
  end

  // ----------------------------------------
  // Clock source
  // ----------------------------------------
  always_comb begin
    case (mode)
      4'h0: half_nxt = `SPC_HALF_FOSC4;
      4'h1: half_nxt = `SPC_HALF_FOSC16;
      4'h2: half_nxt = `SPC_HALF_FOSC64;
      4'h3: half_nxt = `SPC_HALF_FOSC64;
      4'h8: half_nxt = {CNT_W'({baud_r, 1'b0}) + CNT_W'(2)};
      4'hA: half_nxt = {CNT_W'({baud_r, 1'b0}) + CNT_W'(2)};
      default: half_nxt = `SPC_HALF_FOSC16;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      half_r <= `SPC_HALF_FOSC16;
    end else begin
      half_r <= half_nxt;
    end
  end

  // Firmware master and slaves do not use the generator
  assign gen_run = en && xfer_run_i && is_master &&
                   (mode != spc_pkg::SPC_I2C_M_FW);

  spc_baud_gen #(
    .CNT_W(CNT_W)
  ) u_baud (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .run_i(gen_run),
    .idle_lvl_i(is_spi ? pol : 1'b1),
    .half_i(half_r),
    .sclk_o(sclk_o),
    .tick_o(bit_tick_o)
  );

  // ----------------------------------------
  // Pins and mode outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spi_pins_own_o <= 1'b0;
      ss_pin_own_o <= 1'b0;
      i2c_pins_own_o <= 1'b0;
      scl_hold_low_o <= 1'b0;
    end else begin
      spi_pins_own_o <= en && is_spi;
      ss_pin_own_o <= en && is_spi && !is_master && (mode != spc_pkg::SPC_SPI_S_NOSEL);
      i2c_pins_own_o <= en && is_i2c;
      scl_hold_low_o <= en && is_i2c && !is_master && !pol;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_o <= 4'h0;
      i2c_addr10_o <= 1'b0;
      i2c_start_stop_irq_o <= 1'b0;
      i2c_fw_master_o <= 1'b0;
    end else begin
      mode_o <= mode;
      i2c_addr10_o <= (mode == spc_pkg::SPC_I2C_S_10) || (mode == spc_pkg::SPC_I2C_S_10_SS);
      i2c_start_stop_irq_o <= (mode == spc_pkg::SPC_I2C_S_7_SS) ||
                              (mode == spc_pkg::SPC_I2C_S_10_SS);
      i2c_fw_master_o <= en && (mode == spc_pkg::SPC_I2C_M_FW);
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    case (reg_addr_i)
      `SPC_OFS_CON1: rdata_nxt = con1_r;
      `SPC_OFS_BAUD: rdata_nxt = baud_r;
      `SPC_OFS_BUF: rdata_nxt = buf_r;
      `SPC_OFS_IRQ_STAT: rdata_nxt = {5'h00, irq_stat};
      `SPC_OFS_IRQ_MASK: rdata_nxt = {5'h00, irq_mask_r};
      `SPC_OFS_STATUS: rdata_nxt = {5'h00, shift_busy_i, buf_full_r, cfg_err};
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

endmodule

`default_nettype wire

// ===== logic/spc_sticky.sv
// Sticky event flag: set wins over clear.
// Assumes a synchronous, active-low reset copy from the top.
`timescale 1ns/100ps
`default_nettype none

module spc_sticky (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Set and clear
  input wire logic set_i,
  input wire logic clr_i,
  // Flag
  output logic q_o
);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b0;
    end else if (set_i) begin
      q_o <= 1'b1;
    end else if (clr_i) begin
      q_o <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ===== sim/spc_engine_model.sv
// Shift engine stand-in for the control block.
// Assumes the bench pulses rx_req_i for one cycle per received byte.
`timescale 1ns/100ps
`default_nettype none

module spc_engine_model #(
  parameter int BUSY_CYC = 20
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // From block and bench
  input wire logic tx_load_i,
  input wire logic rx_req_i,
  input wire logic [7:0] rx_byte_i,
  // To block
  output logic shift_busy_o,
  output logic rx_done_o,
  output logic [7:0] rx_data_o
);
  // ----------------------------------------
  // Busy after load, byte on request
  // ----------------------------------------
  int busy_cnt;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_cnt <= 0;
      rx_done_o <= 1'b0;
      rx_data_o <= 8'h00;
    end else begin
      if (tx_load_i) begin
        busy_cnt <= BUSY_CYC;
      end else if (busy_cnt > 0) begin
        busy_cnt <= busy_cnt - 1;
      end
      rx_done_o <= rx_req_i;
      rx_data_o <= rx_req_i ? rx_byte_i : ~rx_data_o;
    end
  end
  assign shift_busy_o = (busy_cnt > 0);
endmodule

`default_nettype wire

// ===== sim/spc_serial_port_control_assertions.sv
// Port checker for the control block.
// Assumes it is bound into spc_serial_port_control.
`include "spc_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module spc_serial_port_control_assertions (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic shift_busy_i,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_load_o,
  input wire logic [3:0] mode_o,
  input wire logic i2c_addr10_o,
  input wire logic i2c_fw_master_o,
  input wire logic spi_pins_own_o,
  input wire logic ss_pin_own_o,
  input wire logic i2c_pins_own_o,
  input wire logic bit_tick_o,
  input wire logic scl_hold_low_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // Buffer load
  // ----------------------------------------
  sequence s_buf_wr;
    reg_wr_i && reg_addr_i == `SPC_OFS_BUF && !shift_busy_i && (spi_pins_own_o || i2c_pins_own_o);
  endsequence
  sequence s_load;
    tx_load_o && tx_data_o == $past(reg_wdata_i);
  endsequence
  a_load_after_wr: assert property (s_buf_wr |=> s_load)
    else $error("buffer write not loaded");
  a_load_cause: assert property (tx_load_o |-> $past(reg_wr_i) && !$past(shift_busy_i))
    else $error("load without accepted write");
  // ----------------------------------------
  // Mode decode and pins
  // ----------------------------------------
  a_spi_mode: assert property (spi_pins_own_o |-> (mode_o <= 4'h5 || mode_o == 4'hA))
    else $error("spi pins owned in other mode");
  a_i2c_mode: assert property (i2c_pins_own_o |-> mode_o inside {4'h7, 4'h8, 4'hB, 4'hE, 4'hF})
    else $error("i2c pins owned in other mode");
  a_ss_free: assert property (ss_pin_own_o |-> spi_pins_own_o && mode_o == 4'h4)
    else $error("select pin owned wrongly");
  a_fw_master: assert property (i2c_fw_master_o |-> i2c_pins_own_o && mode_o == 4'hB)
    else $error("firmware master decode wrong");
  a_addr10_dec: assert property (i2c_addr10_o == (mode_o == 4'h7 || mode_o == 4'hF))
    else $error("ten bit address decode wrong");
  a_stretch_src: assert property (scl_hold_low_o |-> i2c_pins_own_o && mode_o inside {4'h7, 4'hE, 4'hF})
    else $error("clock stretch outside slave");
  a_tick_gap: assert property (bit_tick_o |=> !bit_tick_o [*3])
    else $error("clock period too short");
endmodule

bind spc_serial_port_control spc_serial_port_control_assertions u_spc_serial_port_control_assertions (
  .clk_i, .rst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .shift_busy_i, .tx_data_o, .tx_load_o,
  .mode_o, .i2c_addr10_o, .i2c_fw_master_o, .spi_pins_own_o, .ss_pin_own_o, .i2c_pins_own_o,
  .bit_tick_o, .scl_hold_low_o);

`default_nettype wire

// ===== sim/tb_spc_serial_port_control.sv
// Self-checking bench for the control block.
// Assumes the engine model on the shift engine side.
`timescale 1ns/100ps
`default_nettype none

module tb_spc_serial_port_control;
  logic clk_i = 1'b0, rst_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, rx_byte = 8'h00, reg_rdata_o;
  logic i2c_tx_dir_i = 1'b0, xfer_run_i = 1'b0, rx_req = 1'b0, shift_busy_i, rx_done_i;
  logic [7:0] rx_data_i, tx_data_o;
  logic [3:0] mode_o;
  logic tx_load_o, i2c_addr10_o, i2c_start_stop_irq_o, i2c_fw_master_o, spi_pins_own_o;
  logic ss_pin_own_o, i2c_pins_own_o, sclk_o, bit_tick_o, scl_hold_low_o, irq_o;
  int error_cnt = 0, samples_checked = 0, per;

  spc_serial_port_control u_spc_serial_port_control (.clk_i, .rst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .shift_busy_i, .rx_done_i, .rx_data_i,
    .i2c_tx_dir_i, .xfer_run_i, .tx_data_o, .tx_load_o, .mode_o, .i2c_addr10_o,
    .i2c_start_stop_irq_o, .i2c_fw_master_o, .spi_pins_own_o, .ss_pin_own_o, .i2c_pins_own_o,
    .sclk_o, .bit_tick_o, .scl_hold_low_o, .irq_o);
  spc_engine_model u_spc_engine_model (.clk_i, .rst_n_i, .tx_load_i(tx_load_o),
    .rx_req_i(rx_req), .rx_byte_i(rx_byte), .shift_busy_o(shift_busy_i),
    .rx_done_o(rx_done_i), .rx_data_o(rx_data_i));

  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(nm, reg_rdata_o, exp);
  endtask
  task automatic rx(input logic [7:0] b);
    @(posedge clk_i);
    rx_req <= 1'b1;
    rx_byte <= b;
    @(posedge clk_i);
    rx_req <= 1'b0;
    cyc(2);
  endtask
  function automatic logic [7:0] exp_dec(input logic [3:0] m);
    exp_dec = {2'b00, m <= 4'h5 || m == 4'hA, m inside {4'h7, 4'h8, 4'hB, 4'hE, 4'hF},
      m == 4'h4, m == 4'h7 || m == 4'hF, m >= 4'hE, m == 4'hB};
  endfunction
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rc(8'h00, 8'h00, "con1 reset");
    rc(8'h0C, 8'h00, "irq reset");
    rc(8'hFC, 8'h00, "unmapped");
    chk("own reset", {spi_pins_own_o, i2c_pins_own_o, ss_pin_own_o}, 8'h00);
  endtask
  task automatic t_modes();
    for (int i = 0; i < 16; i++) begin
      wr(8'h00, {4'h2, i[3:0]});
      cyc(3);
      chk("decode", {2'b00, spi_pins_own_o, i2c_pins_own_o, ss_pin_own_o, i2c_addr10_o,
        i2c_start_stop_irq_o, i2c_fw_master_o}, exp_dec(i[3:0]));
      chk("mode", {4'h0, mode_o}, {4'h0, i[3:0]});
    end
    wr(8'h00, 8'h0E);
    cyc(3);
    chk("disabled", {spi_pins_own_o, i2c_pins_own_o, ss_pin_own_o}, 8'h00);
  endtask
  task automatic t_clock();
    logic [23:0] tb [3] = '{24'h01_00_10, 24'h0A_02_0C, 24'h08_03_10};
    wr(8'h00, 8'h21);
    cyc(3);
    chk("idle low", sclk_o, 8'h00);
    for (int i = 0; i < 3; i++) begin
      wr(8'h04, tb[i][15:8]);
      wr(8'h00, 8'h30 | tb[i][23:16]);
      cyc(3);
      chk("idle high", sclk_o, 8'h01);
      @(posedge clk_i);
      xfer_run_i <= 1'b1;
      cyc(1);
      for (int k = 0; k < 300 && bit_tick_o !== 1'b1; k++) cyc(1);
      cyc(1);
      for (per = 1; per < 300 && bit_tick_o !== 1'b1; per++) cyc(1);
      chk("period", per[7:0], tb[i][7:0]);
      @(posedge clk_i);
      xfer_run_i <= 1'b0;
    end
    rc(8'h04, 8'h03, "baud");
    wr(8'h04, 8'h02);
    rc(8'h14, 8'h01, "cfg err");
  endtask
  task automatic t_coll();
    wr(8'h10, 8'h01);
    rc(8'h10, 8'h01, "mask");
    wr(8'h00, 8'h21);
    cyc(3);
    wr(8'h08, 8'h11);
    #1;
    chk("tx load", tx_load_o, 8'h01);
    wr(8'h08, 8'h22);
    #1;
    chk("no load", tx_load_o, 8'h00);
    cyc(2);
    chk("tx data", tx_data_o, 8'h11);
    rc(8'h00, 8'hA1, "coll set");
    rc(8'h14, 8'h04, "busy");
    chk("irq on", irq_o, 8'h01);
    wr(8'h00, 8'h21);
    rc(8'h00, 8'h21, "coll clear");
    wr(8'h0C, 8'h01);
    cyc(2);
    chk("irq off", irq_o, 8'h00);
    wr(8'h10, 8'h00);
    cyc(25);
    wr(8'h08, 8'h33);
    wr(8'h08, 8'h44);
    cyc(2);
    chk("irq masked", irq_o, 8'h00);
    rc(8'h0C, 8'h01, "coll sticky");
  endtask
  task automatic t_ovf();
    wr(8'h00, 8'h24);
    cyc(3);
    rx(8'h55);
    rc(8'h08, 8'h55, "rx byte");
    rx(8'h66);
    rx(8'h77);
    rc(8'h14, 8'h02, "buf full");
    rc(8'h00, 8'h64, "spi ovf");
    rc(8'h08, 8'h66, "discard");
    wr(8'h00, 8'h21);
    cyc(3);
    rx(8'h01);
    rx(8'h02);
    rc(8'h00, 8'h21, "master no ovf");
    rc(8'h08, 8'h01, "master rx");
    wr(8'h00, 8'h3E);
    i2c_tx_dir_i <= 1'b1;
    cyc(3);
    rx(8'h03);
    rx(8'h04);
    rc(8'h00, 8'h3E, "i2c tx ovf");
    rc(8'h08, 8'h03, "i2c rx");
    @(posedge clk_i);
    i2c_tx_dir_i <= 1'b0;
    rx(8'h05);
    rx(8'h06);
    rc(8'h00, 8'h7E, "i2c ovf");
    rc(8'h0C, 8'h07, "irq all");
  endtask
  task automatic t_stretch();
    logic [7:0] v [3] = '{8'h2E, 8'h3E, 8'h28};
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, v[i]);
      cyc(3);
      chk("stretch", scl_hold_low_o, {7'h00, i == 0});
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(3);
    t_reset();
    t_modes();
    t_clock();
    t_coll();
    t_ovf();
    t_stretch();
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    cyc(3);
    @(posedge clk_i);
    rst_n_i <= 1'b1;
    cyc(3);
    t_reset();
    conclude();
  end
endmodule

`default_nettype wire
